// ==== rcr_config_regs.sv ====
// Host-reachable configuration register bank of the serial video reclocker
// How it works
// RL1: Equalizer bit 9 enables input attenuation
// RL2: Equalizer bit 8 offset correction, resets one
// RL3: Gain bits: input b bit 7, a bit 4
// RL4: Enable bits: input b bit 3, a bit 0
// RL5: Enable off gives LOW; gain picks MED/HIGH
// RL6: Driver bits 9/8 select 400mV when set
// RL7: Driver boost fields 7:5 and 4:2, reset 2
// RL8: Driver bits 1/0 enable de-emphasis
// RL9: Top bits 8:7 signal-absent threshold
// RL10: Top bits 6:5 signal-absent detection method
// RL11: Top bit 4 mutes output while signal absent
// RL12: Top bit 3 powers device down
// RL13: Top bit 2 floats serial output when deselected
// RL14: Top bit 1 disables crystal buffer
// RL15: Top bit 0 inverts retimed data polarity
// RL16: Command reset bit low restores defaults
// RL17: Reserved bits read zero, ignore writes
`timescale 1ns/100ps
`include "rcr_regs.svh"

module rcr_config_regs
  import rcr_pkg::*;
(
  // Clock and reset
  input  wire logic            ref_clk_in,
  input  wire logic            reset_in,
  // Host serial interface
  input  wire logic            host_cs_n_in,
  input  wire logic            host_sck_in,
  input  wire logic            host_sdi_in,
  output logic                 host_sdo_out,
  output logic                 host_sdo_oe_out,
  // Signal-absent indicator from the detector
  input  wire logic            signal_absent_in,
  // Equalizer controls
  output logic                 input_attenuator_on_out,
  output logic                 eq_offset_corr_on_out,
  output rcr_eq_setting_t      serial_input_a_eq_out,
  output rcr_eq_setting_t      serial_input_b_eq_out,
  // Output driver controls
  output logic                 serial_output_a_half_swing_out,
  output logic                 serial_output_b_half_swing_out,
  output logic [2:0]           serial_output_a_boost_out,
  output logic [2:0]           serial_output_b_boost_out,
  output logic                 serial_output_a_deemph_on_out,
  output logic                 serial_output_b_deemph_on_out,
  // Top level controls
  output logic [1:0]           signal_absent_threshold_out,
  output logic [1:0]           signal_absent_method_out,
  output logic                 output_mute_out,
  output logic                 power_down_out,
  output logic                 crystal_buffer_off_out,
  output logic                 data_invert_out
);

  localparam rcr_state_t RESET_STATE = '{
    eq_reg:     `RCR_EQ_RESET,
    drv_reg:    `RCR_DRV_RESET,
    top_reg:    `RCR_TOP_RESET,
    sck:        1'b0,
    delay_line: 32'hffffffff,
    bit_cnt:    5'h00,
    cmd:        16'h0000,
    rd_data:    16'h0000,
    sdo:        1'b1,
    mute:       1'b0,
    eq_a:       RCR_EQ_LOW,
    eq_b:       RCR_EQ_LOW
  };

  rcr_state_t s_q;
  rcr_state_t s_d;

  // Equalizer setting from enable and gain bits
  function automatic rcr_eq_setting_t eq_decode(input logic en, input logic gain);
    rcr_eq_setting_t r;
    // RL5: enable gates the gain
    if (!en) begin
      r = RCR_EQ_LOW;
    end else if (gain) begin
      r = RCR_EQ_HIGH;
    end else begin
      r = RCR_EQ_MED;
    end
    return r;
  endfunction

  logic        sck_rise;
  logic        sck_fall;
  logic [15:0] word_in;
  logic        addressed;
  logic        bit_in;

  assign sck_rise  = host_sck_in & ~s_q.sck & ~host_cs_n_in;
  assign sck_fall  = ~host_sck_in & s_q.sck & ~host_cs_n_in;
  assign word_in   = {s_q.delay_line[14:0], host_sdi_in};
  assign addressed = (s_q.cmd[`RCR_CMD_CHAIN_MSB:`RCR_CMD_CHAIN_LSB] == 7'h00);

  always_comb begin
    s_d     = s_q;
    s_d.sck = host_sck_in;
    bit_in  = host_sdi_in;

    // Frame position restarts whenever chip select drops away
    if (host_cs_n_in) begin
      s_d.bit_cnt = 5'h00;
    end

    if (sck_rise) begin
      // Read data replaces the data slot on its way to the output
      if (s_q.bit_cnt > `RCR_CMD_LAST_BIT && addressed && s_q.cmd[`RCR_CMD_RW_BIT]) begin
        bit_in = s_q.rd_data[4'(`RCR_DATA_LAST_BIT - s_q.bit_cnt)];
      end
      s_d.delay_line = {s_q.delay_line[30:0], bit_in};
      s_d.bit_cnt    = s_q.bit_cnt + 5'h01;

      if (s_q.bit_cnt == `RCR_CMD_LAST_BIT) begin
        s_d.cmd = word_in;
        if (word_in[`RCR_CMD_CHAIN_MSB:`RCR_CMD_CHAIN_LSB] != 7'h00) begin
          // Pass the command downstream with its chain position decremented
          s_d.delay_line[`RCR_CMD_CHAIN_MSB:`RCR_CMD_CHAIN_LSB] =
            word_in[`RCR_CMD_CHAIN_MSB:`RCR_CMD_CHAIN_LSB] - 7'h01;
        end else if (!word_in[`RCR_CMD_RST_N_BIT]) begin
          // RL16: command reset restores defaults
          s_d.eq_reg  = `RCR_EQ_RESET;
          s_d.drv_reg = `RCR_DRV_RESET;
          s_d.top_reg = `RCR_TOP_RESET;
        end else begin
          unique case (word_in[`RCR_CMD_ADDR_MSB:`RCR_CMD_ADDR_LSB])
            `RCR_EQ_ADDR:  s_d.rd_data = s_q.eq_reg;
            `RCR_DRV_ADDR: s_d.rd_data = s_q.drv_reg;
            `RCR_TOP_ADDR: s_d.rd_data = s_q.top_reg;
            default:       s_d.rd_data = 16'h0000;
          endcase
        end
      end

      if (s_q.bit_cnt == `RCR_DATA_LAST_BIT && addressed && s_q.cmd[`RCR_CMD_RST_N_BIT]
          && !s_q.cmd[`RCR_CMD_RW_BIT]) begin
        // RL17: reserved positions are masked off on write
        unique case (s_q.cmd[`RCR_CMD_ADDR_MSB:`RCR_CMD_ADDR_LSB])
          `RCR_EQ_ADDR:  s_d.eq_reg  = word_in & `RCR_EQ_MASK;
          `RCR_DRV_ADDR: s_d.drv_reg = word_in & `RCR_DRV_MASK;
          `RCR_TOP_ADDR: s_d.top_reg = word_in & `RCR_TOP_MASK;
          default:       s_d.eq_reg  = s_q.eq_reg;
        endcase
      end
    end

    // Output changes on the falling serial clock edge
    if (sck_fall) begin
      s_d.sdo = s_q.delay_line[31];
    end

    // RL3: gain bits for each input
    // RL4: enable bits for each input
    s_d.eq_a = eq_decode(s_d.eq_reg[`RCR_EQUALIZER_ON_A_BIT], s_d.eq_reg[`RCR_EQUALIZER_BOOST_BIT_A_BIT]);
    s_d.eq_b = eq_decode(s_d.eq_reg[`RCR_EQUALIZER_ON_B_BIT], s_d.eq_reg[`RCR_EQUALIZER_BOOST_BIT_B_BIT]);

    // RL11: auto mute on signal absence
    s_d.mute = s_d.top_reg[`RCR_TOP_AMUTE_BIT] & signal_absent_in;
  end

  always_ff @(posedge ref_clk_in) begin
    if (reset_in) begin
      s_q <= RESET_STATE;
    end else begin
      s_q <= s_d;
    end
  end

  assign host_sdo_out = s_q.sdo;
  // RL13: float output when deselected
  assign host_sdo_oe_out = ~(s_q.top_reg[`RCR_TOP_TRI_BIT] & host_cs_n_in);

  // RL1: attenuator enable
  assign input_attenuator_on_out = s_q.eq_reg[`RCR_EQ_ATTEN_BIT];
  // RL2: offset correction enable
  assign eq_offset_corr_on_out   = s_q.eq_reg[`RCR_EQ_OFFS_BIT];
  assign serial_input_a_eq_out   = s_q.eq_a;
  assign serial_input_b_eq_out   = s_q.eq_b;

  // RL6: swing selection
  assign serial_output_a_half_swing_out = s_q.drv_reg[`RCR_DRV_SWING_A_BIT];
  assign serial_output_b_half_swing_out = s_q.drv_reg[`RCR_DRV_SWING_B_BIT];
  // RL7: boost level fields
  assign serial_output_a_boost_out = s_q.drv_reg[`RCR_DRV_BOOST_A_MSB:`RCR_DRV_BOOST_A_LSB];
  assign serial_output_b_boost_out = s_q.drv_reg[`RCR_DRV_BOOST_B_MSB:`RCR_DRV_BOOST_B_LSB];
  // RL8: de-emphasis enables
  assign serial_output_a_deemph_on_out = s_q.drv_reg[`RCR_DRV_DEEMP_A_BIT];
  assign serial_output_b_deemph_on_out = s_q.drv_reg[`RCR_DRV_DEEMP_B_BIT];

  // RL9: detection threshold
  assign signal_absent_threshold_out = s_q.top_reg[`RCR_TOP_THR_MSB:`RCR_TOP_THR_LSB];
  // RL10: detection method
  assign signal_absent_method_out    = s_q.top_reg[`RCR_TOP_METH_MSB:`RCR_TOP_METH_LSB];
  assign output_mute_out             = s_q.mute;
  // RL12: power down control
  assign power_down_out              = s_q.top_reg[`RCR_TOP_PDOWN_BIT];
  // RL14: crystal buffer disable
  assign crystal_buffer_off_out      = s_q.top_reg[`RCR_TOP_XTAL_BIT];
  // RL15: polarity invert
  assign data_invert_out             = s_q.top_reg[`RCR_TOP_POL_BIT];

endmodule

// ==== rcr_regs.svh ====
// Register offsets, field positions, reset values and command word layout
`ifndef RCR_REGS_SVH
`define RCR_REGS_SVH

// Register offsets
`define RCR_EQ_ADDR        5'h00
`define RCR_DRV_ADDR       5'h01
`define RCR_TOP_ADDR       5'h02

// Equalizer register fields
`define RCR_EQ_ATTEN_BIT   9
`define RCR_EQ_OFFS_BIT    8
`define RCR_EQUALIZER_BOOST_BIT_B_BIT  7
`define RCR_EQUALIZER_BOOST_BIT_A_BIT  4
`define RCR_EQUALIZER_ON_B_BIT    3
`define RCR_EQUALIZER_ON_A_BIT    0
`define RCR_EQ_MASK        16'h0399
`define RCR_EQ_RESET       16'h0100

// Output driver register fields
`define RCR_DRV_SWING_B_BIT 9
`define RCR_DRV_SWING_A_BIT 8
`define RCR_DRV_BOOST_B_MSB 7
`define RCR_DRV_BOOST_B_LSB 5
`define RCR_DRV_BOOST_A_MSB 4
`define RCR_DRV_BOOST_A_LSB 2
`define RCR_DRV_DEEMP_B_BIT 1
`define RCR_DRV_DEEMP_A_BIT 0
`define RCR_DRV_MASK        16'h03ff
`define RCR_DRV_RESET       16'h0348

// Top level register fields
`define RCR_TOP_THR_MSB    8
`define RCR_TOP_THR_LSB    7
`define RCR_TOP_METH_MSB   6
`define RCR_TOP_METH_LSB   5
`define RCR_TOP_AMUTE_BIT  4
`define RCR_TOP_PDOWN_BIT  3
`define RCR_TOP_TRI_BIT    2
`define RCR_TOP_XTAL_BIT   1
`define RCR_TOP_POL_BIT    0
`define RCR_TOP_MASK       16'h01ff
`define RCR_TOP_RESET      16'h0000

// Host command word layout
`define RCR_CMD_RW_BIT     15
`define RCR_CMD_RST_N_BIT  12
`define RCR_CMD_CHAIN_MSB  11
`define RCR_CMD_CHAIN_LSB  5
`define RCR_CMD_ADDR_MSB   4
`define RCR_CMD_ADDR_LSB   0
`define RCR_CMD_LAST_BIT   5'd15
`define RCR_DATA_LAST_BIT  5'd31

`endif

// ==== rcr_pkg.sv ====
// Types shared by the reclocker configuration register bank
package rcr_pkg;

  typedef enum logic [2:0] {
    RCR_EQ_LOW  = 3'b001,
    RCR_EQ_MED  = 3'b010,
    RCR_EQ_HIGH = 3'b100
  } rcr_eq_setting_t;

  typedef struct packed {
    logic [15:0]     eq_reg;
    logic [15:0]     drv_reg;
    logic [15:0]     top_reg;
    logic            sck;
    logic [31:0]     delay_line;
    logic [4:0]      bit_cnt;
    logic [15:0]     cmd;
    logic [15:0]     rd_data;
    logic            sdo;
    logic            mute;
    rcr_eq_setting_t eq_a;
    rcr_eq_setting_t eq_b;
  } rcr_state_t;

endpackage

// ==== rcr_config_regs_monitor.sv ====
// Port-level checker for the configuration register bank
`timescale 1ns/100ps
module rcr_config_regs_monitor
  import rcr_pkg::*;
(
  // Clock, reset, host side, signal-absent input and mute output
  input wire logic            ref_clk_in, reset_in, host_cs_n_in, signal_absent_in,
  input wire logic            host_sdo_out, host_sdo_oe_out, output_mute_out,
  // Control outputs
  input wire logic            input_attenuator_on_out, eq_offset_corr_on_out,
  input wire rcr_eq_setting_t serial_input_a_eq_out, serial_input_b_eq_out,
  input wire logic            serial_output_a_half_swing_out, serial_output_a_deemph_on_out,
  input wire logic [2:0]      serial_output_a_boost_out,
  input wire logic [1:0]      signal_absent_threshold_out, signal_absent_method_out,
  input wire logic            power_down_out, data_invert_out
);
  default clocking @(posedge ref_clk_in); endclocking
  default disable iff (reset_in);
  sequence s_idle2;
    host_cs_n_in [*2];
  endsequence
  a_oe_selected:
    assert property (!host_cs_n_in |-> host_sdo_oe_out) else $error("sdo floats while selected");
  a_mute_cause:
    assert property (!$past(signal_absent_in) |-> !output_mute_out) else $error("mute without absence");
  a_eq_onehot:
    assert property ($onehot(serial_input_a_eq_out) && $onehot(serial_input_b_eq_out)) else $error("eq code");
  a_idle_regs:
    assert property (s_idle2 |=> $stable({power_down_out, data_invert_out, serial_output_a_boost_out}))
      else $error("control changed while idle");
  a_idle_sdo:
    assert property (s_idle2 |=> $stable(host_sdo_out)) else $error("sdo changed while idle");
  a_reset_eq:
    assert property (disable iff (1'b0) reset_in |=> !input_attenuator_on_out && eq_offset_corr_on_out
      && serial_input_a_eq_out == RCR_EQ_LOW && serial_input_b_eq_out == RCR_EQ_LOW) else $error("eq reset");
  a_reset_drv:
    assert property (disable iff (1'b0) reset_in |=> {serial_output_a_half_swing_out, serial_output_a_boost_out,
      serial_output_a_deemph_on_out} == 5'h14) else $error("driver reset");
  a_reset_top:
    assert property (disable iff (1'b0) reset_in |=> {signal_absent_threshold_out, signal_absent_method_out,
      power_down_out, data_invert_out, output_mute_out} == 7'h00) else $error("top reset");
endmodule
bind rcr_config_regs rcr_config_regs_monitor u_mon (.ref_clk_in, .reset_in, .host_cs_n_in, .signal_absent_in,
  .host_sdo_out, .host_sdo_oe_out, .output_mute_out, .input_attenuator_on_out, .eq_offset_corr_on_out,
  .serial_input_a_eq_out, .serial_input_b_eq_out, .serial_output_a_half_swing_out, .serial_output_a_deemph_on_out,
  .serial_output_a_boost_out, .signal_absent_threshold_out, .signal_absent_method_out, .power_down_out,
  .data_invert_out);

// ==== rcr_config_regs_tb.sv ====
// Self-checking bench for the configuration register bank
`timescale 1ns/100ps
module rcr_config_regs_tb
  import rcr_pkg::*;
;
  logic ref_clk_in = 0, reset_in = 1, host_cs_n_in = 1, host_sck_in = 0, host_sdi_in = 0, signal_absent_in = 0;
  logic host_sdo_out, host_sdo_oe_out, input_attenuator_on_out, eq_offset_corr_on_out, output_mute_out;
  rcr_eq_setting_t serial_input_a_eq_out, serial_input_b_eq_out;
  logic serial_output_a_half_swing_out, serial_output_b_half_swing_out, serial_output_a_deemph_on_out;
  logic serial_output_b_deemph_on_out, power_down_out, crystal_buffer_off_out, data_invert_out;
  logic [2:0]  serial_output_a_boost_out, serial_output_b_boost_out;
  logic [1:0]  signal_absent_threshold_out, signal_absent_method_out;
  logic [31:0] rx;
  logic [15:0] e = 16'h0100, d = 16'h0348, t = 16'h0000, m;
  logic [4:0]  a;
  int          n_errors = 0, tests_run = 0, cycles = 0;
  // Rows of address and write data
  logic [20:0] rows [9] = '{21'h00ffff, 21'h000009, 21'h000090, 21'h01ffff, 21'h010000, 21'h010295,
                            21'h02ffff, 21'h020040, 21'h051234};
  wire [24:0]  act = {input_attenuator_on_out, eq_offset_corr_on_out, serial_input_a_eq_out, serial_input_b_eq_out,
    serial_output_b_half_swing_out, serial_output_a_half_swing_out, serial_output_b_boost_out,
    serial_output_a_boost_out, serial_output_b_deemph_on_out, serial_output_a_deemph_on_out,
    signal_absent_threshold_out, signal_absent_method_out, power_down_out, crystal_buffer_off_out, data_invert_out};

  rcr_config_regs u_dut (.ref_clk_in, .reset_in, .host_cs_n_in, .host_sck_in, .host_sdi_in, .host_sdo_out,
    .host_sdo_oe_out, .signal_absent_in, .input_attenuator_on_out, .eq_offset_corr_on_out, .serial_input_a_eq_out,
    .serial_input_b_eq_out, .serial_output_a_half_swing_out, .serial_output_b_half_swing_out,
    .serial_output_a_boost_out, .serial_output_b_boost_out, .serial_output_a_deemph_on_out,
    .serial_output_b_deemph_on_out, .signal_absent_threshold_out, .signal_absent_method_out, .output_mute_out,
    .power_down_out, .crystal_buffer_off_out, .data_invert_out);

  always #2 ref_clk_in = ~ref_clk_in;

  always @(posedge ref_clk_in) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      n_errors++;
      conclude();
    end
  end

  function automatic logic [2:0] dec(logic en, logic g);
    return !en ? 3'b001 : (g ? 3'b100 : 3'b010);
  endfunction

  function automatic logic [24:0] model();
    return {e[9], e[8], dec(e[0], e[4]), dec(e[3], e[7]), d[9:0], t[8:5], t[3], t[1], t[0]};
  endfunction

  task automatic chk(input logic [31:0] x, input logic [31:0] y);
    tests_run++;
    if (x !== y) begin
      n_errors++;
      $display("MISMATCH t=%0t exp=%h got=%h", $time, x, y);
    end
  endtask

  // Each SCK level lasts two clocks; SDO is captured just before each rise
  task automatic xfer(input logic [31:0] w);
    for (int i = 31; i >= 0; i--) begin
      host_sdi_in = w[i];
      host_sck_in = 0;
      repeat (2) @(negedge ref_clk_in);
      rx = {rx[30:0], host_sdo_out};
      host_sck_in = 1;
      repeat (2) @(negedge ref_clk_in);
    end
    // Final fall gets its own time step so the next frame never drives SCK twice at once
    host_sck_in = 0;
    repeat (2) @(negedge ref_clk_in);
  endtask

  task automatic op(input logic [15:0] c, input logic [15:0] w);
    host_cs_n_in = 0;
    @(negedge ref_clk_in);
    xfer({c, w});
    xfer(32'hffffffff);
    host_cs_n_in = 1;
    repeat (2) @(negedge ref_clk_in);
  endtask

  task automatic conclude();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (6) @(negedge ref_clk_in);
    reset_in = 0;
    chk(model(), act);
    for (int i = 0; i < 9; i++) begin
      a = rows[i][20:16];
      m = a == 0 ? 16'h0399 : a == 1 ? 16'h03ff : a == 2 ? 16'h01ff : 16'h0000;
      op(16'h1000 | a, rows[i][15:0]);
      op(16'h9000 | a, 16'hffff);
      if (a == 0) e = rows[i][15:0] & m;
      if (a == 1) d = rows[i][15:0] & m;
      if (a == 2) t = rows[i][15:0] & m;
      chk(rows[i][15:0] & m, rx[15:0]);
      chk(model(), act);
    end
    // All-zero frame carries a low register-reset bit
    op(16'h0000, 16'h0000);
    e = 16'h0100;
    d = 16'h0348;
    t = 16'h0000;
    chk(model(), act);
    op(16'h1002, 16'h0014);
    chk(0, host_sdo_oe_out);
    host_cs_n_in = 0;
    @(negedge ref_clk_in);
    chk(1, host_sdo_oe_out);
    host_cs_n_in = 1;
    signal_absent_in = 1;
    repeat (2) @(negedge ref_clk_in);
    chk(1, output_mute_out);
    reset_in = 1;
    repeat (2) @(negedge ref_clk_in);
    reset_in = 0;
    @(negedge ref_clk_in);
    chk(0, output_mute_out);
    chk(1, host_sdo_oe_out);
    conclude();
  end
endmodule
